// *** cie_consts.svh ***
// Constants for the instruction execution subset: widths, encodings, fields, reset values
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define CIE_IW          14
`define CIE_DW          8
`define CIE_AW          7
`define CIE_PCW         15
`define CIE_LITW        11
`define CIE_LATW        7
`define CIE_UPW         4

// ****************************************************************
// Instruction fields
// ****************************************************************
`define CIE_OPC_HI      13
`define CIE_OPC_LO      8
`define CIE_DEST_BIT    7
`define CIE_FADDR_HI    6
`define CIE_FADDR_LO    0
`define CIE_LIT_HI      10
`define CIE_LIT_LO      0
`define CIE_JMP_HI      13
`define CIE_JMP_LO      11
`define CIE_LAT_HI      6
`define CIE_LAT_LO      3

// ****************************************************************
// Encodings (six-bit major opcode, three-bit jump class)
// ****************************************************************
`define CIE_OPC_INVERT  6'h09
`define CIE_OPC_ZERO    6'h01
`define CIE_OPC_MINUS   6'h03
`define CIE_OPC_MSKIP   6'h0B
`define CIE_JMP_CLASS   3'h5
`define CIE_DEST_ACC    1'b0
`define CIE_DEST_FILE   1'b1

// ****************************************************************
// Reset values and arithmetic constants
// ****************************************************************
`define CIE_ACC_RST     8'h00
`define CIE_ZERO_RST    1'b0
`define CIE_PC_RST      15'h0000
`define CIE_ADDR_RST    7'h00
`define CIE_DATA_ZERO   8'h00
`define CIE_DATA_ONE    8'h01

`endif

// *** cie_pkg.sv ***
// Types shared by the execution subset: decoded instruction, result bundle, sequencer states
`include "cie_consts.svh"

package cie_pkg;

	typedef enum logic [2:0] {
		CIE_OP_NONE   = 3'h0,
		CIE_OP_INVERT = 3'h1,
		CIE_OP_ZFILE  = 3'h2,
		CIE_OP_ZACC   = 3'h3,
		CIE_OP_MINUS  = 3'h4,
		CIE_OP_MSKIP  = 3'h5,
		CIE_OP_JUMP   = 3'h6
	} cie_op_e;

	// Gray path: execute -> discard -> execute
	typedef enum logic [1:0] {
		CIE_ST_EXEC    = 2'h0,
		CIE_ST_DISCARD = 2'h1
	} cie_state_e;

	typedef struct packed {
		cie_op_e                 op;
		logic                    dest;
		logic [`CIE_AW-1:0]      faddr;
		logic [`CIE_LITW-1:0]    lit;
	} cie_dec_s;

	typedef struct packed {
		logic [`CIE_DW-1:0]      value;
		logic                    to_file;
		logic                    to_acc;
		logic                    upd_zero;
		logic                    zero_val;
		logic                    skip;
		logic                    jump;
	} cie_res_s;

endpackage

// *** cie_alu.sv ***
// Result datapath: computes value, destination, flag update and flow change for one instruction
`timescale 1ns/1ns
`include "cie_consts.svh"

module cie_alu
	import cie_pkg::*;
(
	input  wire cie_dec_s           i_dec,
	input  wire logic [`CIE_DW-1:0] i_fdata,
	output wire cie_res_s           o_res
);

	// ****************************************************************
	// Operation results
	// ****************************************************************
	wire logic [`CIE_DW-1:0] inv_val;
	wire logic [`CIE_DW-1:0] dec_val;
	wire logic               is_inv;
	wire logic               is_zf;
	wire logic               is_za;
	wire logic               is_dec;
	wire logic               is_dsk;
	wire logic               has_dest;
	wire logic               val_zero;

	assign inv_val  = ~i_fdata;
	assign dec_val  = i_fdata - `CIE_DATA_ONE;
	assign is_inv   = (i_dec.op == CIE_OP_INVERT);
	assign is_zf    = (i_dec.op == CIE_OP_ZFILE);
	assign is_za    = (i_dec.op == CIE_OP_ZACC);
	assign is_dec   = (i_dec.op == CIE_OP_MINUS);
	assign is_dsk   = (i_dec.op == CIE_OP_MSKIP);
	assign has_dest = is_inv | is_dec | is_dsk;

	assign o_res.value    = is_inv ? inv_val :
	                        (is_dec | is_dsk) ? dec_val : `CIE_DATA_ZERO;
	assign val_zero       = (o_res.value == `CIE_DATA_ZERO);
	// Destination bit picks accumulator or file
	assign o_res.to_file  = is_zf | (has_dest & (i_dec.dest == `CIE_DEST_FILE));
	assign o_res.to_acc   = is_za | (has_dest & (i_dec.dest == `CIE_DEST_ACC));
	// Skip op and jump leave the flag alone
	assign o_res.upd_zero = is_inv | is_dec | is_zf | is_za;
	assign o_res.zero_val = (is_zf | is_za) ? 1'b1 : val_zero;
	assign o_res.skip     = is_dsk & val_zero;
	assign o_res.jump     = (i_dec.op == CIE_OP_JUMP);

endmodule

// *** cie_core.sv ***
// Execution stage for the invert, clear, decrement, decrement-skip and absolute jump ops
`timescale 1ns/1ns
`include "cie_consts.svh"

module cie_core
	import cie_pkg::*;
(
	input  wire logic                  I_MCLK,
	input  wire logic                  I_RESETN,
	input  wire logic                  i_INSTR_VALID,
	input  wire logic [`CIE_IW-1:0]    i_INSTR,
	input  wire logic [`CIE_DW-1:0]    i_FILE_RDATA,
	input  wire logic [`CIE_LATW-1:0]  i_UPPER_JUMP_LATCH,
	output logic      [`CIE_AW-1:0]    o_FILE_ADDR,
	output logic      [`CIE_DW-1:0]    o_FILE_WDATA,
	output logic                       o_FILE_WE,
	output logic      [`CIE_DW-1:0]    o_ACC,
	output logic                       o_ZERO,
	output logic      [`CIE_PCW-1:0]   o_PC_TARGET,
	output logic                       o_PC_LOAD,
	output logic                       o_NOP_SLOT,
	output logic                       o_DISCARD_PENDING
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	function automatic cie_dec_s decode(input logic [`CIE_IW-1:0] ins);
		cie_dec_s d;
		logic [`CIE_OPC_HI-`CIE_OPC_LO:0] opc;
		d       = '0;
		opc     = ins[`CIE_OPC_HI:`CIE_OPC_LO];
		d.dest  = ins[`CIE_DEST_BIT];
		d.faddr = ins[`CIE_FADDR_HI:`CIE_FADDR_LO];
		d.lit   = ins[`CIE_LIT_HI:`CIE_LIT_LO];
		if (ins[`CIE_JMP_HI:`CIE_JMP_LO] == `CIE_JMP_CLASS) begin
			d.op = CIE_OP_JUMP;
		end else if (opc == `CIE_OPC_INVERT) begin
			d.op = CIE_OP_INVERT;
		end else if (opc == `CIE_OPC_ZERO) begin
			// Same major code; destination bit tells file from accumulator
			d.op = (d.dest == `CIE_DEST_FILE) ? CIE_OP_ZFILE : CIE_OP_ZACC;
		end else if (opc == `CIE_OPC_MINUS) begin
			d.op = CIE_OP_MINUS;
		end else if (opc == `CIE_OPC_MSKIP) begin
			d.op = CIE_OP_MSKIP;
		end else begin
			d.op = CIE_OP_NONE;
		end
		return d;
	endfunction

	// ****************************************************************
	// State and registers
	// ****************************************************************
	cie_state_e                state_q;
	cie_state_e                state_d;
	logic [`CIE_DW-1:0]        acc_q;
	logic [`CIE_DW-1:0]        acc_d;
	logic                      zero_q;
	logic                      zero_d;
	logic [`CIE_AW-1:0]        faddr_q;
	logic [`CIE_DW-1:0]        wdata_q;
	logic                      we_q;
	logic                      we_d;
	logic [`CIE_PCW-1:0]       pc_q;
	logic [`CIE_PCW-1:0]       pc_d;
	logic                      pcld_q;
	logic                      pcld_d;
	logic                      nop_q;
	logic                      nop_d;

	// Mirrors the sequencer so the pending output needs no decode
	logic                      pend_q;
	logic                      pend_d;

	// ****************************************************************
	// Execute
	// ****************************************************************
	wire logic                 in_exec;
	wire logic                 run;
	wire logic                 drop;
	wire cie_dec_s             dec;
	wire logic                 fwd_hit;
	wire logic [`CIE_DW-1:0]   fdata;
	wire logic [`CIE_PCW-1:0]  jump_pc;
	cie_res_s                  res;

	assign in_exec = (state_q == CIE_ST_EXEC);
	assign run     = i_INSTR_VALID & in_exec;
	// Fetched instruction after a taken skip or a jump is thrown away
	assign drop    = i_INSTR_VALID & ~in_exec;
	assign dec     = run ? decode(i_INSTR) : '0;

	// The file write lands one cycle late; forward it so a back-to-back
	// access to the same address sees the fresh value, not the stale one.
	assign fwd_hit = we_q & (faddr_q == dec.faddr);
	assign fdata   = fwd_hit ? wdata_q : i_FILE_RDATA;

	cie_alu u_alu (
		.i_dec   (dec),
		.i_fdata (fdata),
		.o_res   (res)
	);

	// Target is latch bits six to three over the eleven-bit literal
	assign jump_pc = {i_UPPER_JUMP_LATCH[`CIE_LAT_HI:`CIE_LAT_LO], dec.lit};

	assign acc_d   = (run & res.to_acc) ? res.value : acc_q;
	assign zero_d  = (run & res.upd_zero) ? res.zero_val : zero_q;
	assign we_d    = run & res.to_file;
	assign pcld_d  = run & res.jump;
	assign pc_d    = pcld_d ? jump_pc : pc_q;
	assign nop_d   = drop;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Skip or jump costs one discarded slot; a discarded slot never chains
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CIE_ST_EXEC: begin
				if (run & (res.skip | res.jump)) begin
					state_d = CIE_ST_DISCARD;
				end
			end
			CIE_ST_DISCARD: begin
				// Idle cycles keep the discard armed for the next real fetch
				if (drop) begin
					state_d = CIE_ST_EXEC;
				end
			end
			default: begin
				state_d = CIE_ST_EXEC;
			end
		endcase
	end

	// Registered copy so the pending output comes straight from a flop
	assign pend_d  = (state_d == CIE_ST_DISCARD);

	// ****************************************************************
	// Flip-flops
	// ****************************************************************
	// Sequencer and its mirrored pending flag
	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state_q <= CIE_ST_EXEC;
			pend_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			pend_q  <= pend_d;
		end
	end

	// Architectural accumulator and zero flag
	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			acc_q   <= `CIE_ACC_RST;
			zero_q  <= `CIE_ZERO_RST;
		end else begin
			acc_q   <= acc_d;
			zero_q  <= zero_d;
		end
	end

	// Jump target and the one-cycle strobes
	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pc_q    <= `CIE_PC_RST;
			pcld_q  <= 1'b0;
			nop_q   <= 1'b0;
			we_q    <= 1'b0;
		end else begin
			pc_q    <= pc_d;
			pcld_q  <= pcld_d;
			nop_q   <= nop_d;
			we_q    <= we_d;
		end
	end

	// Address and data hold their last write when idle
	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			faddr_q <= `CIE_ADDR_RST;
			wdata_q <= `CIE_DATA_ZERO;
		end else if (we_d) begin
			faddr_q <= dec.faddr;
			wdata_q <= res.value;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_FILE_ADDR       = faddr_q;
	assign o_FILE_WDATA      = wdata_q;
	assign o_FILE_WE         = we_q;
	assign o_ACC             = acc_q;
	assign o_ZERO            = zero_q;
	assign o_PC_TARGET       = pc_q;
	assign o_PC_LOAD         = pcld_q;
	assign o_NOP_SLOT        = nop_q;
	// Flop copy of the discard state; no decode between flop and pin
	assign o_DISCARD_PENDING = pend_q;

endmodule

// *** cie_core_sva.sv ***
// Concurrent checks on the ports of the execution subset
`timescale 1ns/1ns
`include "cie_consts.svh"

module cie_core_sva (
	input wire logic        I_MCLK,
	input wire logic        I_RESETN,
	input wire logic        i_INSTR_VALID,
	input wire logic [13:0] i_INSTR,
	input wire logic [7:0]  i_FILE_RDATA,
	input wire logic [6:0]  i_UPPER_JUMP_LATCH,
	input wire logic [6:0]  o_FILE_ADDR,
	input wire logic [7:0]  o_FILE_WDATA,
	input wire logic        o_FILE_WE,
	input wire logic [7:0]  o_ACC,
	input wire logic        o_ZERO,
	input wire logic [14:0] o_PC_TARGET,
	input wire logic        o_PC_LOAD,
	input wire logic        o_NOP_SLOT,
	input wire logic        o_DISCARD_PENDING
);
	// ****************************************
	// A pending discard swallows the instruction
	// ****************************************
	wire       ex  = i_INSTR_VALID && !o_DISCARD_PENDING;
	wire [5:0] opc = i_INSTR[13:8];
	wire [7:0] res = o_FILE_WE ? o_FILE_WDATA : o_ACC;
	// The file is written at the strobe edge, so a same-address read sees the pending write
	wire [7:0] opnd = (o_FILE_WE && o_FILE_ADDR == i_INSTR[6:0]) ? o_FILE_WDATA : i_FILE_RDATA;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);

	a_invert_result: assert property (ex && opc == `CIE_OPC_INVERT |=>
		res == ~$past(opnd) && o_FILE_WE == $past(i_INSTR[7])
		&& o_ZERO == ($past(opnd) == 8'hFF)) else $error("invert result wrong");
	a_zero_file: assert property (ex && opc == `CIE_OPC_ZERO && i_INSTR[7] |=>
		o_FILE_WE && o_FILE_WDATA == 8'h00 && o_ZERO
		&& o_FILE_ADDR == $past(i_INSTR[6:0])) else $error("file clear wrong");
	a_zero_acc: assert property (ex && opc == `CIE_OPC_ZERO && !i_INSTR[7] |=>
		!o_FILE_WE && o_ACC == 8'h00 && o_ZERO) else $error("acc clear wrong");
	a_minus_result: assert property (ex && opc == `CIE_OPC_MINUS |=>
		res == $past(opnd) - 8'h01 && o_FILE_WE == $past(i_INSTR[7])
		&& o_ZERO == ($past(opnd) == 8'h01)) else $error("decrement wrong");
	a_skip_route: assert property (ex && opc == `CIE_OPC_MSKIP |=>
		res == $past(opnd) - 8'h01 && $stable(o_ZERO)
		&& o_DISCARD_PENDING == ($past(opnd) == 8'h01)) else $error("skip op wrong");
	a_jump_target: assert property (ex && i_INSTR[13:11] == `CIE_JMP_CLASS |=>
		o_PC_LOAD && o_DISCARD_PENDING && $stable(o_ZERO) && o_PC_TARGET
		== {$past(i_UPPER_JUMP_LATCH[6:3]), $past(i_INSTR[10:0])}) else $error("jump wrong");
	a_discard_slot: assert property (o_DISCARD_PENDING && i_INSTR_VALID |=>
		o_NOP_SLOT && !o_FILE_WE && !o_PC_LOAD && !o_DISCARD_PENDING
		&& $stable(o_ACC) && $stable(o_ZERO)) else $error("discard slot wrong");
	a_pending_hold: assert property (o_DISCARD_PENDING && !i_INSTR_VALID |=>
		o_DISCARD_PENDING && !o_NOP_SLOT) else $error("discard lost on idle cycle");
endmodule

bind cie_core cie_core_sva u_sva (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
	.i_INSTR_VALID(i_INSTR_VALID), .i_INSTR(i_INSTR), .i_FILE_RDATA(i_FILE_RDATA),
	.i_UPPER_JUMP_LATCH(i_UPPER_JUMP_LATCH), .o_FILE_ADDR(o_FILE_ADDR),
	.o_FILE_WDATA(o_FILE_WDATA), .o_FILE_WE(o_FILE_WE), .o_ACC(o_ACC), .o_ZERO(o_ZERO),
	.o_PC_TARGET(o_PC_TARGET), .o_PC_LOAD(o_PC_LOAD), .o_NOP_SLOT(o_NOP_SLOT),
	.o_DISCARD_PENDING(o_DISCARD_PENDING));

// *** tb_top.sv ***
// Self-checking bench for the execution subset
`timescale 1ns/1ns
`include "cie_consts.svh"

module tb_top;
	logic        mclk, rst_n, valid, we, z, pcl, nop, pend;
	logic [13:0] ins;
	logic [7:0]  rd, wd, acc;
	logic [6:0]  lat, fa;
	logic [14:0] pct;
	int          num_errors = 0;
	int          checks = 0;

	cie_core dut (.I_MCLK(mclk), .I_RESETN(rst_n), .i_INSTR_VALID(valid), .i_INSTR(ins),
		.i_FILE_RDATA(rd), .i_UPPER_JUMP_LATCH(lat), .o_FILE_ADDR(fa), .o_FILE_WDATA(wd),
		.o_FILE_WE(we), .o_ACC(acc), .o_ZERO(z), .o_PC_TARGET(pct), .o_PC_LOAD(pcl),
		.o_NOP_SLOT(nop), .o_DISCARD_PENDING(pend));

	// ****************************************
	// Shared drivers
	// ****************************************
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// Results land on the edge that takes the instruction, so sample just past it
	task automatic issue(input logic [13:0] w, input logic [7:0] d);
		@(posedge mclk);
		valid <= 1'b1;
		ins   <= w;
		rd    <= d;
		@(posedge mclk);
		valid <= 1'b0;
		#1;
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_invert();
		issue({`CIE_OPC_INVERT, 1'b0, 7'h05}, 8'h0A);
		chk(acc === 8'hF5 && z === 1'b0 && we === 1'b0, "invert to acc");
		issue({`CIE_OPC_INVERT, 1'b1, 7'h7F}, 8'hFF);
		chk(we === 1'b1 && wd === 8'h00 && fa === 7'h7F && z === 1'b1, "invert to file");
	endtask

	task automatic t_clear();
		issue({`CIE_OPC_INVERT, 1'b0, 7'h01}, 8'h00);
		issue({`CIE_OPC_ZERO, 1'b1, 7'h33}, 8'h5A);
		chk(we === 1'b1 && wd === 8'h00 && fa === 7'h33 && z === 1'b1, "file clear");
		issue({`CIE_OPC_INVERT, 1'b0, 7'h01}, 8'h00);
		issue({`CIE_OPC_ZERO, 1'b0, 7'h00}, 8'h77);
		chk(acc === 8'h00 && z === 1'b1 && we === 1'b0, "acc clear");
	endtask

	task automatic t_minus();
		issue({`CIE_OPC_MINUS, 1'b1, 7'h20}, 8'h01);
		chk(we === 1'b1 && wd === 8'h00 && fa === 7'h20 && z === 1'b1, "dec to file");
		issue({`CIE_OPC_MINUS, 1'b0, 7'h21}, 8'h00);
		chk(acc === 8'hFF && z === 1'b0 && we === 1'b0, "dec to acc");
	endtask

	// Back-to-back ops on one address: the second must see the first's write
	task automatic t_forward();
		@(posedge mclk);
		valid <= 1'b1;
		ins   <= {`CIE_OPC_MINUS, 1'b1, 7'h40};
		rd    <= 8'h10;
		@(posedge mclk);
		ins   <= {`CIE_OPC_INVERT, 1'b0, 7'h40};
		rd    <= 8'h10;
		@(posedge mclk);
		valid <= 1'b0;
		#1;
		chk(acc === 8'hF0 && wd === 8'h0F && fa === 7'h40 && we === 1'b0, "forward");
		issue(14'h3FFF, 8'h00);
		chk(acc === 8'hF0 && z === 1'b0 && we === 1'b0 && pcl === 1'b0 && pend === 1'b0
			&& nop === 1'b0, "unknown op does nothing");
	endtask

	task automatic t_skip();
		issue({`CIE_OPC_ZERO, 1'b0, 7'h00}, 8'h00);
		issue({`CIE_OPC_MSKIP, 1'b0, 7'h10}, 8'h05);
		chk(acc === 8'h04 && z === 1'b1 && pend === 1'b0, "skip op nonzero");
		issue({`CIE_OPC_INVERT, 1'b0, 7'h02}, 8'h00);
		chk(nop === 1'b0 && acc === 8'hFF && z === 1'b0, "next op runs");
		issue({`CIE_OPC_MSKIP, 1'b1, 7'h11}, 8'h01);
		chk(we === 1'b1 && wd === 8'h00 && z === 1'b0 && pend === 1'b1, "skip op zero");
		@(posedge mclk);
		#1;
		chk(pend === 1'b1 && nop === 1'b0, "idle keeps discard");
		issue({`CIE_OPC_INVERT, 1'b0, 7'h02}, 8'hFF);
		chk(nop === 1'b1 && acc === 8'hFF && z === 1'b0 && pend === 1'b0, "skipped op");
	endtask

	task automatic t_jump();
		logic [10:0] lit [3] = '{11'h7FF, 11'h000, 11'h005};
		logic [6:0]  lv  [3] = '{7'h78, 7'h07, 7'h28};
		logic [14:0] exp [3] = '{15'h7FFF, 15'h0000, 15'h2805};
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk);
			lat <= lv[k];
			issue({`CIE_JMP_CLASS, lit[k]}, 8'h00);
			chk(pcl === 1'b1 && pct === exp[k] && pend === 1'b1 && z === 1'b0, "jump");
			issue({`CIE_OPC_ZERO, 1'b0, 7'h00}, 8'h00);
			chk(nop === 1'b1 && pcl === 1'b0 && z === 1'b0 && acc === 8'hFF, "jump slot");
		end
	endtask

	// A reset in mid-run drops a pending discard
	task automatic t_reset_mid();
		issue({`CIE_JMP_CLASS, 11'h123}, 8'h00);
		chk(pend === 1'b1 && pct === 15'h2923, "jump before reset");
		@(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		#1;
		chk(pend === 1'b0 && pcl === 1'b0 && acc === 8'h00 && z === 1'b0 && pct === 15'h0000,
			"mid-run reset");
		@(posedge mclk);
		rst_n <= 1'b1;
		issue({`CIE_OPC_INVERT, 1'b0, 7'h03}, 8'h0F);
		chk(nop === 1'b0 && pend === 1'b0 && acc === 8'hF0, "first op after reset");
	endtask

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Cuts a hang short
	initial begin
		repeat (3000) @(posedge mclk);
		num_errors++;
		complete_run();
	end

	initial begin
		rst_n = 1'b0;
		valid = 1'b0;
		ins   = 14'h0000;
		rd    = 8'h00;
		lat   = 7'h00;
		repeat (4) @(posedge mclk);
		#1;
		chk(acc === 8'h00 && z === 1'b0 && pct === 15'h0000 && we === 1'b0, "reset");
		@(posedge mclk);
		rst_n <= 1'b1;
		t_invert();
		t_clear();
		t_minus();
		t_forward();
		t_skip();
		t_jump();
		t_reset_mid();
		complete_run();
	end
endmodule
